/* File: sim/adcc_analog_model.sv */
// Purpose: Analog macro stand-in
// Assumes: Bench sets the input level as a code
// Notes: Off state inverts the level, so bad codes show
`timescale 1ns/1ns
module adcc_analog_model
  import adcc_pkg::*;
(
  input wire adcc_analog_t ana_ctrl,
  input wire logic [11:0] level,
  output logic [11:0] conv_code
);
  // Powered off gives no valid code
  assign conv_code = ana_ctrl.power_on ? level : ~level;
endmodule : adcc_analog_model

/* File: sim/adcc_ctrl_monitor.sv */
// Purpose: Port checks for adcc_ctrl
// Assumes: Bound from the bench
// Notes: Writes show one edge later
`timescale 1ns/1ns
module adcc_ctrl_monitor
  import adcc_pkg::*;
#(
  parameter int PINS = 8,
  parameter int RES_W = 12
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [PINS-1:0] pin_pullup_cfg,
  input wire logic [RES_W-1:0] conv_code,
  input wire adcc_analog_t ana_ctrl,
  input wire logic [PINS-1:0] pin_analog_sel,
  input wire logic [PINS-1:0] pin_pullup_en,
  input wire logic [PINS-1:0] pin_out_en_n,
  input wire logic conv_irq
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (srst);
  property p_pull; pin_pullup_en == (pin_pullup_cfg & ~pin_analog_sel); endproperty
  a_pull: assert property (p_pull) else $error("pull-high left on");
  property p_dir; (pin_out_en_n & pin_analog_sel) == pin_analog_sel; endproperty
  a_dir: assert property (p_dir) else $error("analog pin driven");
  property p_rdz; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside slot");
  property p_pwr; $past(reg_wr && reg_addr == 3'h0) |-> ana_ctrl.power_on == !$past(reg_wdata[5]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power bit");
  property p_hold; $past(reg_wr && reg_addr == 3'h0 && reg_wdata[7]) |-> ana_ctrl.hold_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("start high not holding");
  property p_vref; $past(reg_wr && reg_addr == 3'h1) |-> ana_ctrl.use_ref_pin == $past(reg_wdata[3]);
  endproperty
  a_vref: assert property (p_vref) else $error("reference choice");
  property p_chan; $past(reg_wr && reg_addr == 3'h1) |-> ana_ctrl.channel[4] == $past(reg_wdata[7]);
  endproperty
  a_chan: assert property (p_chan) else $error("channel high bit");
  property p_irq; $past(reg_wr && reg_addr == 3'h5 && !reg_wdata[0]) |-> !conv_irq; endproperty
  a_irq: assert property (p_irq) else $error("irq without global enable");
  property p_smp; ana_ctrl.hold_reset |-> !ana_ctrl.sample; endproperty
  a_smp: assert property (p_smp) else $error("sample in reset");
endmodule : adcc_ctrl_monitor

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for adcc_ctrl
// Assumes: Strobes one cycle, gap between
// Notes: Seeded random levels and channels
`timescale 1ns/1ns
module testbench;
  import adcc_pkg::*;
  logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, conv_irq;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, pin_pullup_cfg = 8'h00, reg_rdata, rv, pe;
  logic [7:0] pin_analog_sel, pin_pullup_en, pin_out_en_n;
  logic [11:0] level = 12'h000, conv_code;
  logic [4:0] ch;
  adcc_analog_t ana_ctrl;
  int fail_count = 0, checks = 0, nsmp = 0, cyc = 0, t0 = 0, tl = 0;
  adcc_ctrl dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_pullup_cfg(pin_pullup_cfg),
    .conv_code(conv_code), .ana_ctrl(ana_ctrl), .pin_analog_sel(pin_analog_sel),
    .pin_pullup_en(pin_pullup_en), .pin_out_en_n(pin_out_en_n), .conv_irq(conv_irq));
  adcc_analog_model model (.ana_ctrl(ana_ctrl), .level(level), .conv_code(conv_code));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ana_ctrl.sample) begin
      if (nsmp == 0) t0 <= cyc;
      tl <= cyc;
      nsmp <= nsmp + 1;
    end
  end
  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask : rd
  function automatic logic [7:0] rst_val(input int i);
    return (i == 0) ? 8'h60 : (i == 6) ? 8'hff : 8'h00;
  endfunction : rst_val
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(17476));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // Index 7 is unmapped and must read zero
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], rv);
      chk("reset", rv, rst_val(i));
    end
    $display("reset values done");
    repeat (4) begin
      pe = 8'($urandom);
      pin_pullup_cfg <= 8'($urandom);
      wr(3'h2, pe);
      chk("sel", pin_analog_sel, pe);
      chk("pull", pin_pullup_en, pin_pullup_cfg & ~pe);
      chk("oen", pin_out_en_n & pe, pe);
    end
    $display("pin routing done");
    // Code 7 halts the converter clock, so pending must stay up
    wr(3'h1, 8'h07);
    wr(3'h0, 8'h80);
    wr(3'h0, 8'h00);
    repeat (200) @(posedge clk);
    rd(3'h0, rv);
    chk("stall", rv[6], 1'b1);
    $display("halted divider done");
    for (int d = 0; d < 7; d++) begin
      level <= 12'($urandom);
      ch = 5'($urandom);
      wr(3'h1, {ch[4], 3'h0, d[0], d[2:0]});
      wr(3'h0, {3'b000, ch[2:0], 2'b00});
      wr(3'h0, {3'b100, ch[2:0], 2'b00});
      chk("hold", ana_ctrl.hold_reset, 1'b1);
      nsmp = 0;
      wr(3'h0, {3'b000, ch[2:0], 2'b00});
      rd(3'h0, rv);
      chk("pend", rv[6], 1'b1);
      chk("chan", {ana_ctrl.channel[4], ana_ctrl.channel[2:0]}, {ch[4], ch[2:0]});
      chk("vref", ana_ctrl.use_ref_pin, d[0]);
      chk("power", ana_ctrl.power_on, 1'b1);
      for (int k = 0; k < 1200 && nsmp < 16; k++) @(posedge clk);
      repeat (3) @(posedge clk);
      chk("ticks", 12'(nsmp), 12'd16);
      if (nsmp != 16) summarize();
      chk("div", 12'(tl - t0), 12'(15 << d));
      rd(3'h0, rv);
      chk("done", rv[6], 1'b0);
      rd(3'h3, rv);
      chk("lo", rv, level[7:0]);
      rd(3'h4, rv);
      chk("hi", rv, {4'h0, level[11:8]});
      rd(3'h5, rv);
      chk("flag", rv[2], 1'b1);
      wr(3'h5, 8'h07);
      chk("irq on", conv_irq, 1'b1);
      wr(3'h5, 8'h06);
      chk("irq off", conv_irq, 1'b0);
      wr(3'h5, 8'h00);
      $display("conversion div code %0d done", d);
    end
    summarize();
  end
endmodule : testbench
bind adcc_ctrl adcc_ctrl_monitor #(.PINS(PINS), .RES_W(RES_W)) u_mon (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_pullup_cfg(pin_pullup_cfg), .conv_code(conv_code),
  .ana_ctrl(ana_ctrl), .pin_analog_sel(pin_analog_sel), .pin_pullup_en(pin_pullup_en),
  .pin_out_en_n(pin_out_en_n), .conv_irq(conv_irq));

/* File: src/adcc_clk_div.sv */
// Purpose: Converter clock tick from system clock, divide by 1 to 64
// Assumes: Code 111 is undefined, treated as stopped
// Notes: One-cycle tick per converter clock period
`timescale 1ns/1ns
`include "adcc_params.svh"
module adcc_clk_div #(
  parameter int CNT_W = 6
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic tick
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] limit;

  always_comb begin
    limit = CNT_W'((1 << div_sel) - 1);
    nxt_cnt = cnt_ff;
    tick = 1'b0;
    if (!run || div_sel == `ADCC_DIV_UNDEF) begin
      // Undefined ratio stops the converter clock rather than guess
      nxt_cnt = '0;
    end else if (cnt_ff >= limit) begin
      nxt_cnt = '0;
      tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : adcc_clk_div

/* File: src/adcc_ctrl.sv */
// Purpose: Conversion control: registers, start sequencing, pin routing
// Assumes: Analog macro samples on ana_ctrl.sample and returns a 12-bit code
// Notes: 8-bit register port, read data one cycle after the read strobe
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "adcc_params.svh"
module adcc_ctrl
  import adcc_pkg::*;
#(
  parameter int PINS = 8,
  parameter int RES_W = 12
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`ADCC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [PINS-1:0] pin_pullup_cfg,
  input wire logic [RES_W-1:0] conv_code,
  output adcc_analog_t ana_ctrl,
  output logic [PINS-1:0] pin_analog_sel,
  output logic [PINS-1:0] pin_pullup_en,
  output logic [PINS-1:0] pin_out_en_n,
  output logic conv_irq
);
  adcc_state_t state_ff;
  adcc_state_t nxt_state;
  logic [7:0] ctrl0_ff;
  logic [7:0] nxt_ctrl0;
  logic [7:0] ctrl1_ff;
  logic [7:0] nxt_ctrl1;
  logic [PINS-1:0] pinen_ff;
  logic [PINS-1:0] nxt_pinen;
  logic [PINS-1:0] portcfg_ff;
  logic [PINS-1:0] nxt_portcfg;
  logic [2:0] intc_ff;
  logic [2:0] nxt_intc;
  logic [RES_W-1:0] res_ff;
  logic [RES_W-1:0] nxt_res;
  logic [4:0] ticks_ff;
  logic [4:0] nxt_ticks;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic start_bit;
  logic start_prev_ff;
  logic start_fall;
  logic conv_tick;
  logic conv_done;

  assign start_bit = ctrl0_ff[`ADCC_C0_START];
  assign start_fall = start_prev_ff && !start_bit;

  adcc_clk_div #(
    .CNT_W(6)
  ) u_div (
    .clk(clk),
    .srst(srst),
    .run(state_ff == ADCC_CONV),
    .div_sel(ctrl1_ff[`ADCC_C1_DIV_LO +: `ADCC_C1_DIV_W]),
    .tick(conv_tick)
  );

  // Sequencer; the core never waits on it
  always_comb begin
    nxt_state = state_ff;
    nxt_ticks = ticks_ff;
    conv_done = 1'b0;
    case (state_ff)
      ADCC_IDLE: begin
        if (start_bit) begin
          nxt_state = ADCC_HOLD;
        end
      end
      ADCC_HOLD: begin
        nxt_ticks = '0;
        if (start_fall) begin
          nxt_state = ADCC_CONV;
        end
      end
      ADCC_CONV: begin
        if (start_bit) begin
          // A new rising start aborts and resets the converter
          nxt_state = ADCC_HOLD;
        end else if (conv_tick) begin
          if (ticks_ff == `ADCC_CONV_TICKS - 5'h1) begin
            nxt_state = ADCC_IDLE;
            conv_done = 1'b1;
          end else begin
            nxt_ticks = ticks_ff + 5'h1;
          end
        end
      end
      default: begin
        nxt_state = ADCC_IDLE;
      end
    endcase
  end

  // Register writes and hardware updates
  always_comb begin
    nxt_ctrl0 = ctrl0_ff;
    nxt_ctrl1 = ctrl1_ff;
    nxt_pinen = pinen_ff;
    nxt_portcfg = portcfg_ff;
    nxt_intc = intc_ff;
    nxt_res = res_ff;
    if (reg_wr) begin
      if (reg_addr == `ADCC_OFF_CTRL0) begin
        // Pending flag is read-only to software
        nxt_ctrl0 = {reg_wdata[7], ctrl0_ff[`ADCC_C0_PEND], reg_wdata[5:0]};
      end else if (reg_addr == `ADCC_OFF_CTRL1) begin
        nxt_ctrl1 = reg_wdata;
      end else if (reg_addr == `ADCC_OFF_PINEN) begin
        nxt_pinen = reg_wdata[PINS-1:0];
      end else if (reg_addr == `ADCC_OFF_PORTCFG) begin
        nxt_portcfg = reg_wdata[PINS-1:0];
      end else if (reg_addr == `ADCC_OFF_INTC) begin
        nxt_intc = reg_wdata[2:0];
      end
    end
    if (start_bit) begin
      nxt_ctrl0[`ADCC_C0_PEND] = 1'b1;
    end else if (conv_done) begin
      nxt_ctrl0[`ADCC_C0_PEND] = 1'b0;
    end
    if (conv_done) begin
      nxt_res = conv_code;
      nxt_intc[`ADCC_IC_AIF] = 1'b1; // set beats clear
    end
  end

  // Read data in the cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `ADCC_OFF_CTRL0) begin
        nxt_rdata = ctrl0_ff;
      end else if (reg_addr == `ADCC_OFF_CTRL1) begin
        nxt_rdata = ctrl1_ff;
      end else if (reg_addr == `ADCC_OFF_PINEN) begin
        nxt_rdata = 8'(pinen_ff);
      end else if (reg_addr == `ADCC_OFF_PORTCFG) begin
        nxt_rdata = 8'(portcfg_ff);
      end else if (reg_addr == `ADCC_OFF_INTC) begin
        nxt_rdata = {5'h00, intc_ff};
      end else if (reg_addr == `ADCC_OFF_RES_LO) begin
        nxt_rdata = res_ff[7:0];
      end else if (reg_addr == `ADCC_OFF_RES_HI) begin
        nxt_rdata = {`ADCC_RES_HI_ZERO, res_ff[RES_W-1:8]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ADCC_IDLE;
      ticks_ff <= 5'h00;
      ctrl0_ff <= `ADCC_C0_RST;
      ctrl1_ff <= `ADCC_C1_RST;
      pinen_ff <= '0;
      portcfg_ff <= '1;
      intc_ff <= 3'h0;
      res_ff <= '0;
      rdata_ff <= 8'h00;
      start_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ticks_ff <= nxt_ticks;
      ctrl0_ff <= nxt_ctrl0;
      ctrl1_ff <= nxt_ctrl1;
      pinen_ff <= nxt_pinen;
      portcfg_ff <= nxt_portcfg;
      intc_ff <= nxt_intc;
      res_ff <= nxt_res;
      rdata_ff <= nxt_rdata;
      start_prev_ff <= start_bit;
    end
  end

  assign reg_rdata = rdata_ff;

  // Code step and offsets are set by the analog macro from this reference
  always_comb begin
    // Channel bit 3 does not exist, so it is held low
    ana_ctrl.channel = {ctrl1_ff[`ADCC_C1_CH_HI], 1'b0,
                        ctrl0_ff[`ADCC_C0_CH_LO +: `ADCC_C0_CH_LO_W]};
    ana_ctrl.use_ref_pin = ctrl1_ff[`ADCC_C1_VREF];
    ana_ctrl.power_on = !ctrl0_ff[`ADCC_C0_POFF];
    // Start high resets at once, even before the abort reaches the state
    ana_ctrl.hold_reset = (state_ff != ADCC_CONV) || start_bit;
    ana_ctrl.sample = (state_ff == ADCC_CONV) && !start_bit && conv_tick;
  end

  // Portcfg bit high means input; analog selection forces the driver off
  assign pin_analog_sel = pinen_ff;
  assign pin_pullup_en = pin_pullup_cfg & ~pinen_ff;
  assign pin_out_en_n = portcfg_ff | pinen_ff;

  assign conv_irq = intc_ff[`ADCC_IC_AIF] && intc_ff[`ADCC_IC_GIE]
                    && intc_ff[`ADCC_IC_AIE];
endmodule : adcc_ctrl

/* File: src/adcc_params.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, byte registers at index offsets
// Notes: Definitions only
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

`define ADCC_ADDR_W 3
`define ADCC_OFF_CTRL0 3'h0
`define ADCC_OFF_CTRL1 3'h1
`define ADCC_OFF_PINEN 3'h2
`define ADCC_OFF_RES_LO 3'h3
`define ADCC_OFF_RES_HI 3'h4
`define ADCC_OFF_INTC 3'h5
`define ADCC_OFF_PORTCFG 3'h6

// converter_control_0 fields
`define ADCC_C0_START 7
`define ADCC_C0_PEND 6
`define ADCC_C0_POFF 5
`define ADCC_C0_CH_LO 2
`define ADCC_C0_CH_LO_W 3
`define ADCC_C0_RST 8'h60
// converter_control_1 fields
`define ADCC_C1_CH_HI 7
`define ADCC_C1_VREF 3
`define ADCC_C1_DIV_LO 0
`define ADCC_C1_DIV_W 3
`define ADCC_C1_RST 8'h00
// Interrupt control fields
`define ADCC_IC_GIE 0
`define ADCC_IC_AIE 1
`define ADCC_IC_AIF 2

`define ADCC_DIV_UNDEF 3'h7
`define ADCC_CONV_TICKS 5'h10
`define ADCC_RES_HI_ZERO 4'h0

`endif

/* File: src/adcc_pkg.sv */
// Purpose: Types shared by the conversion control block
// Assumes: Constants live in adcc_params.svh
// Notes: Types only
package adcc_pkg;
  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b001,
    ADCC_HOLD = 3'b010,
    ADCC_CONV = 3'b100
  } adcc_state_t;

  typedef struct packed {
    logic [4:0] channel;
    logic use_ref_pin;
    logic power_on;
    logic hold_reset;
    logic sample;
  } adcc_analog_t;
endpackage : adcc_pkg
